// ### rtl/usbi_defines.svh
`ifndef USBI_DEFINES_SVH
`define USBI_DEFINES_SVH

// Register byte offsets on the plain register port
`define USBI_ADDR_W          3
`define USBI_OFS_MODE        3'h0
`define USBI_OFS_RX_ERR      3'h1
`define USBI_OFS_TX_STAT     3'h2
`define USBI_OFS_RX_BUF      3'h3
`define USBI_OFS_TX_BUF      3'h4

// Reset values
`define USBI_RST_MODE        8'h01
`define USBI_RST_RX_ERR      8'h00
`define USBI_RST_TX_STAT     8'h00
`define USBI_RST_RX_BUF      8'hff
`define USBI_RST_TX_BUF      8'hff

// Field positions in the error status register
`define USBI_ERR_PARITY_BIT  2
`define USBI_ERR_FRAMING_BIT 1
`define USBI_ERR_OVERRUN_BIT 0

// Field positions in the transmit status register
`define USBI_TXS_FULL_BIT    1
`define USBI_TXS_BUSY_BIT    0

// Interrupt priority codes, 0 means none pending
`define USBI_PRIO_NONE       2'h0
`define USBI_PRIO_RX_ERR     2'h1
`define USBI_PRIO_RX_DONE    2'h2
`define USBI_PRIO_TX_DONE    2'h3

// Default line bit period in base clock cycles
`define USBI_BIT_CYCLES      16

`endif

// ### rtl/usbi_pkg.sv
package usbi_pkg;

  // Mode register, bit 7 down to bit 0
  typedef struct packed {
    logic channel_enable_bit;
    logic tx_enable_bit;
    logic rx_enable_bit;
    logic parity_sel_hi;
    logic parity_sel_lo;
    logic char_len8;
    logic stop_two;
    logic err_irq_route_sel;
  } usbi_mode_s;

  // One register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } usbi_bus_s;

  // Gray codes along idle, start, data, parity, stop
  typedef enum logic [2:0] {
    USBI_RX_IDLE   = 3'b000,
    USBI_RX_START  = 3'b001,
    USBI_RX_DATA   = 3'b011,
    USBI_RX_PARITY = 3'b010,
    USBI_RX_STOP   = 3'b110
  } usbi_rx_state_e;

  typedef enum logic [2:0] {
    USBI_TX_IDLE   = 3'b000,
    USBI_TX_START  = 3'b001,
    USBI_TX_DATA   = 3'b011,
    USBI_TX_PARITY = 3'b010,
    USBI_TX_STOP1  = 3'b110,
    USBI_TX_STOP2  = 3'b111
  } usbi_tx_state_e;

endpackage

// ### rtl/usbi_uart.sv
`timescale 1ns/100ps
`include "usbi_defines.svh"

module usbi_uart #(
  parameter int unsigned BIT_CYCLES = `USBI_BIT_CYCLES
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Register port
  input  wire usbi_pkg::usbi_bus_s bus_req,
  output logic [7:0]            bus_rdata,
  // Serial line
  input  wire logic             rxd,
  output logic                  txd,
  // Interrupt requests, one-cycle pulses
  output logic                  rx_error_irq,
  output logic                  rx_done_irq,
  output logic                  tx_done_irq,
  output logic [1:0]            irq_top_code
);
  import usbi_pkg::*;

  localparam int unsigned CW = $clog2(BIT_CYCLES);
  localparam logic [CW-1:0] FULL_CNT = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] HALF_CNT = CW'(BIT_CYCLES / 2 - 1);

  usbi_mode_s      mode_reg;
  logic [2:0]      err_flags_reg;
  logic [7:0]      rx_holding_buf;
  logic [7:0]      tx_holding_buf;
  logic            tx_buf_full_flag;
  logic            tx_shift_busy_flag;
  logic            rx_unread_reg;
  usbi_rx_state_e  rx_state_reg;
  logic [CW-1:0]   rx_cnt_reg;
  logic [2:0]      rx_idx_reg;
  logic [7:0]      rx_shift_reg;
  logic            rx_par_reg;
  usbi_tx_state_e  tx_state_reg;
  logic [CW-1:0]   tx_cnt_reg;
  logic [2:0]      tx_idx_reg;
  logic [7:0]      tx_shift_reg;

  logic rx_on;
  logic tx_on;
  logic parity_on;
  logic [2:0] last_idx;
  logic rd_err;
  logic rd_rxbuf;
  logic wr_txbuf;
  logic rx_frame_end;
  logic pe_ev;
  logic fe_ev;
  logic ov_ev;
  logic any_err;
  logic rx_err_ev;
  logic rx_done_ev;
  logic tx_load;
  logic tx_frame_end;
  logic tx_done_ev;

  assign rx_on     = mode_reg.channel_enable_bit & mode_reg.rx_enable_bit;
  assign tx_on     = mode_reg.channel_enable_bit & mode_reg.tx_enable_bit;
  assign parity_on = mode_reg.parity_sel_hi | mode_reg.parity_sel_lo;
  assign last_idx  = mode_reg.char_len8 ? 3'h7 : 3'h6;
  assign rd_err    = bus_req.rd && bus_req.addr == `USBI_OFS_RX_ERR;
  assign rd_rxbuf  = bus_req.rd && bus_req.addr == `USBI_OFS_RX_BUF;
  assign wr_txbuf  = bus_req.wr && bus_req.addr == `USBI_OFS_TX_BUF && tx_on;

  // Receive frame end and its error conditions
  assign rx_frame_end = rx_on && rx_state_reg == USBI_RX_STOP && rx_cnt_reg == '0;
  // Odd mode wants an odd count of ones including the parity bit
  assign pe_ev = rx_frame_end && mode_reg.parity_sel_hi &&
                 ((^{rx_shift_reg, rx_par_reg}) == mode_reg.parity_sel_lo);
  assign fe_ev = rx_frame_end && !rxd;
  assign ov_ev = rx_frame_end && rx_unread_reg;
  assign any_err = pe_ev | fe_ev | ov_ev;
  assign rx_err_ev  = rx_on && any_err && !mode_reg.err_irq_route_sel;
  assign rx_done_ev = rx_frame_end && (!any_err || mode_reg.err_irq_route_sel);

  // Transmit load and frame end
  assign tx_frame_end = tx_on && tx_cnt_reg == '0 &&
                        ((tx_state_reg == USBI_TX_STOP1 && !mode_reg.stop_two) ||
                         tx_state_reg == USBI_TX_STOP2);
  assign tx_load = tx_on && tx_buf_full_flag &&
                   (tx_state_reg == USBI_TX_IDLE || tx_frame_end);
  // Done fires on entry to the last stop bit, not at its end
  // With two stop bits only the second one counts, or done would fire twice
  assign tx_done_ev = tx_on && tx_cnt_reg == '0 &&
                      ((tx_state_reg == USBI_TX_STOP1 && mode_reg.stop_two) ||
                       (!mode_reg.stop_two &&
                        (tx_state_reg == USBI_TX_PARITY ||
                         (tx_state_reg == USBI_TX_DATA && tx_idx_reg == last_idx &&
                          !parity_on))));

  // Mode register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= `USBI_RST_MODE;
    end else if (bus_req.wr && bus_req.addr == `USBI_OFS_MODE) begin
      mode_reg <= bus_req.wdata;
    end
  end

  // Error flags; a new error beats the clearing read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      err_flags_reg <= 3'(`USBI_RST_RX_ERR);
    end else if (!rx_on) begin
      err_flags_reg <= 3'h0;
    end else begin
      if (rd_err) begin
        err_flags_reg <= 3'h0;
      end
      if (pe_ev) begin
        err_flags_reg[`USBI_ERR_PARITY_BIT] <= 1'b1;
      end
      if (fe_ev) begin
        err_flags_reg[`USBI_ERR_FRAMING_BIT] <= 1'b1;
      end
      if (ov_ev) begin
        err_flags_reg[`USBI_ERR_OVERRUN_BIT] <= 1'b1;
      end
    end
  end

  // Receive buffer and its unread marker
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_holding_buf <= `USBI_RST_RX_BUF;
      rx_unread_reg  <= 1'b0;
    end else if (!mode_reg.channel_enable_bit) begin
      rx_holding_buf <= `USBI_RST_RX_BUF;
      rx_unread_reg  <= 1'b0;
    end else if (rx_frame_end && !rx_unread_reg) begin
      rx_holding_buf <= rx_shift_reg;
      rx_unread_reg  <= 1'b1;
    end else if (rd_rxbuf) begin
      rx_unread_reg  <= 1'b0;
    end
  end

  // Receive shifter, samples mid-bit
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_state_reg <= USBI_RX_IDLE;
      rx_cnt_reg   <= '0;
      rx_idx_reg   <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_par_reg   <= 1'b0;
    end else if (!rx_on) begin
      rx_state_reg <= USBI_RX_IDLE;
      rx_cnt_reg   <= '0;
    end else begin
      unique case (rx_state_reg)
        USBI_RX_IDLE: begin
          if (!rxd) begin
            rx_state_reg <= USBI_RX_START;
            rx_cnt_reg   <= HALF_CNT;
            rx_idx_reg   <= 3'h0;
            rx_shift_reg <= 8'h00;
          end
        end
        USBI_RX_START: begin
          if (rx_cnt_reg != '0) begin
            rx_cnt_reg <= rx_cnt_reg - 1'b1;
          end else if (rxd) begin
            rx_state_reg <= USBI_RX_IDLE;
          end else begin
            rx_state_reg <= USBI_RX_DATA;
            rx_cnt_reg   <= FULL_CNT;
          end
        end
        USBI_RX_DATA: begin
          if (rx_cnt_reg != '0) begin
            rx_cnt_reg <= rx_cnt_reg - 1'b1;
          end else begin
            rx_shift_reg[rx_idx_reg] <= rxd;
            rx_idx_reg <= rx_idx_reg + 1'b1;
            rx_cnt_reg <= FULL_CNT;
            if (rx_idx_reg == last_idx) begin
              rx_state_reg <= parity_on ? USBI_RX_PARITY : USBI_RX_STOP;
            end
          end
        end
        USBI_RX_PARITY: begin
          if (rx_cnt_reg != '0) begin
            rx_cnt_reg <= rx_cnt_reg - 1'b1;
          end else begin
            rx_par_reg   <= rxd;
            rx_cnt_reg   <= FULL_CNT;
            rx_state_reg <= USBI_RX_STOP;
          end
        end
        USBI_RX_STOP: begin
          // Only one stop bit is ever checked
          if (rx_cnt_reg != '0) begin
            rx_cnt_reg <= rx_cnt_reg - 1'b1;
          end else begin
            rx_state_reg <= USBI_RX_IDLE;
          end
        end
        default: begin
          rx_state_reg <= USBI_RX_IDLE;
        end
      endcase
    end
  end

  // Transmit buffer; a write while full overwrites, software must avoid it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_holding_buf <= `USBI_RST_TX_BUF;
    end else if (wr_txbuf) begin
      tx_holding_buf <= bus_req.wdata;
    end
  end

  // Buffer-full flag; the write wins over a load in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_buf_full_flag <= 1'b0;
    end else if (!tx_on) begin
      tx_buf_full_flag <= 1'b0;
    end else if (wr_txbuf) begin
      tx_buf_full_flag <= 1'b1;
    end else if (tx_load) begin
      tx_buf_full_flag <= 1'b0;
    end
  end

  // Shift-busy flag
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_shift_busy_flag <= 1'b0;
    end else if (!tx_on) begin
      tx_shift_busy_flag <= 1'b0;
    end else if (tx_load) begin
      tx_shift_busy_flag <= 1'b1;
    end else if (tx_frame_end) begin
      tx_shift_busy_flag <= 1'b0;
    end
  end

  // Transmit shifter; the line idles high whenever sending is off
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_state_reg <= USBI_TX_IDLE;
      tx_cnt_reg   <= '0;
      tx_idx_reg   <= 3'h0;
      tx_shift_reg <= 8'h00;
      txd          <= 1'b1;
    end else if (!tx_on) begin
      tx_state_reg <= USBI_TX_IDLE;
      tx_cnt_reg   <= '0;
      txd          <= 1'b1;
    end else if (tx_load) begin
      tx_state_reg <= USBI_TX_START;
      tx_shift_reg <= tx_holding_buf;
      tx_cnt_reg   <= FULL_CNT;
      tx_idx_reg   <= 3'h0;
      txd          <= 1'b0;
    end else if (tx_state_reg != USBI_TX_IDLE && tx_cnt_reg != '0) begin
      tx_cnt_reg <= tx_cnt_reg - 1'b1;
    end else begin
      tx_cnt_reg <= FULL_CNT;
      unique case (tx_state_reg)
        USBI_TX_IDLE: begin
          tx_cnt_reg <= '0;
          txd        <= 1'b1;
        end
        USBI_TX_START: begin
          tx_state_reg <= USBI_TX_DATA;
          txd          <= tx_shift_reg[0];
        end
        USBI_TX_DATA: begin
          if (tx_idx_reg == last_idx) begin
            tx_state_reg <= parity_on ? USBI_TX_PARITY : USBI_TX_STOP1;
            txd <= parity_on ? (mode_reg.parity_sel_hi &
                   (^(tx_shift_reg & {mode_reg.char_len8, 7'h7f}) ^
                    ~mode_reg.parity_sel_lo)) : 1'b1;
          end else begin
            txd <= tx_shift_reg[tx_idx_reg + 3'h1];
          end
          tx_idx_reg <= tx_idx_reg + 1'b1;
        end
        USBI_TX_PARITY: begin
          tx_state_reg <= USBI_TX_STOP1;
          txd          <= 1'b1;
        end
        USBI_TX_STOP1: begin
          tx_state_reg <= mode_reg.stop_two ? USBI_TX_STOP2 : USBI_TX_IDLE;
          txd          <= 1'b1;
        end
        USBI_TX_STOP2: begin
          tx_state_reg <= USBI_TX_IDLE;
          txd          <= 1'b1;
        end
        default: begin
          tx_state_reg <= USBI_TX_IDLE;
          txd          <= 1'b1;
        end
      endcase
    end
  end

  // Interrupt pulses and the highest pending one
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_error_irq <= 1'b0;
      rx_done_irq  <= 1'b0;
      tx_done_irq  <= 1'b0;
      irq_top_code <= `USBI_PRIO_NONE;
    end else begin
      rx_error_irq <= rx_err_ev;
      rx_done_irq  <= rx_done_ev;
      tx_done_irq  <= tx_done_ev;
      if (rx_err_ev) begin
        irq_top_code <= `USBI_PRIO_RX_ERR;
      end else if (rx_done_ev) begin
        irq_top_code <= `USBI_PRIO_RX_DONE;
      end else if (tx_done_ev) begin
        irq_top_code <= `USBI_PRIO_TX_DONE;
      end else begin
        irq_top_code <= `USBI_PRIO_NONE;
      end
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_rdata <= 8'h00;
    end else if (!bus_req.rd) begin
      bus_rdata <= 8'h00;
    end else begin
      unique case (bus_req.addr)
        `USBI_OFS_MODE:    bus_rdata <= mode_reg;
        `USBI_OFS_RX_ERR:  bus_rdata <= {5'h00, err_flags_reg};
        `USBI_OFS_TX_STAT: bus_rdata <= {6'h00, tx_buf_full_flag, tx_shift_busy_flag};
        `USBI_OFS_RX_BUF:  bus_rdata <= rx_holding_buf;
        `USBI_OFS_TX_BUF:  bus_rdata <= tx_holding_buf;
        default:           bus_rdata <= 8'h00;
      endcase
    end
  end

endmodule

// ### bench/usbi_uart_sva.sv
`timescale 1ns/100ps
module usbi_uart_sva #(
  parameter int unsigned BIT_CYCLES = 16
) (
  // Clock and reset
  input wire logic                ref_clk,
  input wire logic                rst,
  // Register port
  input wire usbi_pkg::usbi_bus_s bus_req,
  input wire logic [7:0]          bus_rdata,
  // Line and requests
  input wire logic                rxd,
  input wire logic                txd,
  input wire logic                rx_error_irq,
  input wire logic                rx_done_irq,
  input wire logic                tx_done_irq,
  input wire logic [1:0]          irq_top_code
);
  import usbi_pkg::*;

  // Shadow of the mode register, so the checks know the enables
  logic [7:0] mode_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_q <= 8'h01;
    end else if (bus_req.wr && bus_req.addr == 3'h0) begin
      mode_q <= bus_req.wdata;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Enables need a settled cycle before level clears show in read data
  sequence rx_off2;
    !mode_q[5] [*2];
  endsequence
  sequence err_rd_off;
    !mode_q[5] ##1 (bus_req.rd && bus_req.addr == 3'h1 && !mode_q[5]);
  endsequence
  sequence buf_rd_off;
    !mode_q[7] ##1 (bus_req.rd && bus_req.addr == 3'h3 && !mode_q[7]);
  endsequence
  sequence txs_rd_off;
    !mode_q[6] ##1 (bus_req.rd && bus_req.addr == 3'h2 && !mode_q[6]);
  endsequence
  // Done rises with the last stop bit, which then stands at least four cycles
  sequence stop_hold;
    txd ##1 (txd && !tx_done_irq) [*3];
  endsequence

  irq_exclusive_a: assert property (rx_error_irq |-> !rx_done_irq)
    else $error("error and done requests together");
  err_route_a: assert property (rx_error_irq |-> mode_q[5] && !mode_q[0])
    else $error("error request with receive off or routed to done");
  rx_off_quiet_a: assert property (rx_off2 |-> !rx_done_irq && !rx_error_irq)
    else $error("receive request while receive disabled");
  prio_err_a: assert property (rx_error_irq |-> irq_top_code == 2'h1)
    else $error("error request not top priority");
  prio_rest_a: assert property (!rx_error_irq |->
    irq_top_code == (rx_done_irq ? 2'h2 : (tx_done_irq ? 2'h3 : 2'h0)))
    else $error("priority code wrong");
  flags_off_a: assert property (err_rd_off |=> bus_rdata == 8'h00)
    else $error("error flags not clear with receive off");
  buf_off_a: assert property (buf_rd_off |=> bus_rdata == 8'hff)
    else $error("receive buffer not all ones with channel off");
  txs_off_a: assert property (txs_rd_off |=> bus_rdata == 8'h00)
    else $error("transmit status not clear with transmit off");
  tx_idle_a: assert property (!mode_q[6] [*3] |-> txd)
    else $error("line not high with transmit off");
  tx_stop_a: assert property (tx_done_irq |-> stop_hold)
    else $error("transmit done outside stop bit");
endmodule

bind usbi_uart usbi_uart_sva #(.BIT_CYCLES(BIT_CYCLES)) i_sva (
  .ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .rxd(rxd),
  .txd(txd), .rx_error_irq(rx_error_irq), .rx_done_irq(rx_done_irq),
  .tx_done_irq(tx_done_irq), .irq_top_code(irq_top_code));

// ### bench/usbi_line_peer.sv
`timescale 1ns/100ps
module usbi_line_peer #(
  parameter int unsigned BIT_CYCLES = 4
) (
  // Clock
  input  wire logic ref_clk,
  // Serial line
  output logic      rxd,
  input  wire logic txd
);
  logic [7:0] got_q[$];
  logic [7:0] got;

  initial rxd = 1'b1;

  task automatic put_bit(input logic v, input int unsigned n);
    @(posedge ref_clk);
    rxd <= v;
    repeat (n - 1) @(posedge ref_clk);
  endtask

  // A low stop is cut short so the line is high before a new start is sought
  task automatic send(input logic [7:0] d, input int nb, input int par, input logic stop);
    put_bit(1'b0, BIT_CYCLES);
    for (int i = 0; i < nb; i++) put_bit(d[i], BIT_CYCLES);
    if (par >= 0) put_bit(par[0], BIT_CYCLES);
    put_bit(stop, stop ? BIT_CYCLES : BIT_CYCLES / 2 + 1);
    put_bit(1'b1, 2 * BIT_CYCLES);
  endtask

  // Eight data bits, no parity, sampled mid-bit
  initial begin
    forever begin
      @(posedge ref_clk);
      if (txd === 1'b0) begin
        repeat (BIT_CYCLES / 2) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYCLES) @(posedge ref_clk);
          got[i] = txd;
        end
        got_q.push_back(got);
        repeat (BIT_CYCLES) @(posedge ref_clk);
      end
    end
  end
endmodule

// ### bench/tb.sv
`timescale 1ns/100ps
module tb;
  import usbi_pkg::*;
  localparam int unsigned BITC = 4;
  logic       ref_clk, rst, rxd, txd, e_irq, d_irq, t_irq;
  usbi_bus_s  req;
  logic [7:0] rdata;
  logic [1:0] top;
  logic [2:0] seen;
  int         n_mismatch = 0, checked = 0, cyc = 0, n_tx = 0;

  usbi_uart #(.BIT_CYCLES(BITC)) i_dut (.ref_clk(ref_clk), .rst(rst), .bus_req(req),
    .bus_rdata(rdata), .rxd(rxd), .txd(txd), .rx_error_irq(e_irq), .rx_done_irq(d_irq),
    .tx_done_irq(t_irq), .irq_top_code(top));
  usbi_line_peer #(.BIT_CYCLES(BITC)) i_peer (.ref_clk(ref_clk), .rxd(rxd), .txd(txd));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Requests are one-cycle pulses, so they are gathered until a scenario looks
  always @(posedge ref_clk) begin
    seen = seen | {e_irq, d_irq, t_irq};
    n_tx += int'(t_irq === 1'b1);
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic final_report();
    if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(posedge ref_clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1 check(what, rdata, exp);
  endtask

  task automatic frame(input logic [7:0] d, input int nb, input int par, input logic stop,
                       input logic [2:0] exp);
    seen = 3'b000;
    i_peer.send(d, nb, par, stop);
    #1 check("requests", {5'h00, seen}, {5'h00, exp});
  endtask

  initial begin
    req = '0;
    rst = 1'b1;
    seen = 3'b000;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    rd(3'h0, 8'h01, "mode");
    rd(3'h1, 8'h00, "rx err");
    rd(3'h2, 8'h00, "tx stat");
    rd(3'h3, 8'hff, "rx buf");
    rd(3'h4, 8'hff, "tx buf");
    rd(3'h7, 8'h00, "unmapped");
    wr(3'h0, 8'he4);
    frame(8'ha5, 8, -1, 1'b1, 3'b010);
    rd(3'h3, 8'ha5, "rx buf");
    frame(8'h11, 8, -1, 1'b1, 3'b010);
    frame(8'h22, 8, -1, 1'b1, 3'b100);
    rd(3'h1, 8'h01, "rx err");
    rd(3'h1, 8'h00, "rx err");
    rd(3'h3, 8'h11, "rx buf");
    // The read lands on the frame-end cycle, so the new flag must survive it
    seen = 3'b000;
    fork
      i_peer.send(8'h5c, 8, -1, 1'b0);
      begin
        repeat (38) @(posedge ref_clk);
        rd(3'h1, 8'h00, "rx err");
      end
    join
    #1 check("requests", {5'h00, seen}, 8'h04);
    rd(3'h1, 8'h02, "rx err");
    rd(3'h3, 8'h5c, "rx buf");
    wr(3'h0, 8'hfc);
    frame(8'h37, 8, int'(~^8'h37), 1'b1, 3'b100);
    rd(3'h1, 8'h04, "rx err");
    rd(3'h3, 8'h37, "rx buf");
    wr(3'h0, 8'hf4);
    frame(8'h37, 8, int'(~^8'h37), 1'b1, 3'b010);
    rd(3'h3, 8'h37, "rx buf");
    wr(3'h0, 8'hec);
    frame(8'h37, 8, 1, 1'b1, 3'b010);
    rd(3'h1, 8'h00, "rx err");
    rd(3'h3, 8'h37, "rx buf");
    wr(3'h0, 8'he5);
    frame(8'h48, 8, -1, 1'b0, 3'b010);
    rd(3'h1, 8'h02, "rx err");
    rd(3'h3, 8'h48, "rx buf");
    wr(3'h0, 8'he0);
    frame(8'hff, 7, -1, 1'b1, 3'b010);
    rd(3'h3, 8'h7f, "rx buf");
    wr(3'h0, 8'he4);
    frame(8'h01, 8, -1, 1'b0, 3'b100);
    wr(3'h0, 8'hc4);
    rd(3'h1, 8'h00, "rx err");
    frame(8'h99, 8, -1, 1'b1, 3'b000);
    rd(3'h3, 8'h01, "rx buf");
    wr(3'h0, 8'he4);
    wr(3'h4, 8'h5a);
    repeat (3) @(posedge ref_clk);
    rd(3'h2, 8'h01, "tx stat");
    wr(3'h4, 8'hc3);
    rd(3'h2, 8'h03, "tx stat");
    rd(3'h4, 8'hc3, "tx buf");
    for (int i = 0; i < 400 && i_peer.got_q.size() < 2; i++) @(posedge ref_clk);
    repeat (3 * BITC) @(posedge ref_clk);
    rd(3'h2, 8'h00, "tx stat");
    check("tx count", 8'(n_tx), 8'h02);
    check("tx bytes", 8'(i_peer.got_q.size()), 8'h02);
    check("tx first", i_peer.got_q[0], 8'h5a);
    check("tx second", i_peer.got_q[1], 8'hc3);
    wr(3'h0, 8'hf6);
    wr(3'h4, 8'h81);
    for (int i = 0; i < 400 && i_peer.got_q.size() < 3; i++) @(posedge ref_clk);
    repeat (5 * BITC) @(posedge ref_clk);
    check("tx count", 8'(n_tx), 8'h03);
    check("tx third", i_peer.got_q[2], 8'h81);
    wr(3'h0, 8'ha4);
    wr(3'h4, 8'h66);
    repeat (60) @(posedge ref_clk);
    rd(3'h2, 8'h00, "tx stat");
    rd(3'h4, 8'h81, "tx buf");
    check("tx count", 8'(n_tx), 8'h03);
    wr(3'h0, 8'h00);
    rd(3'h3, 8'hff, "rx buf");
    final_report();
  end
endmodule
